/* File: hw/erw_pkg.sv */
// Package for the external bus ready/wait-state controller.
// Assumes a single system clock; no software-visible registers.
package erw_pkg;
   // Phase counter width, data bus width and reference divider width
   localparam int unsigned PHASE_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned DIV_W = 2;
   // Reference clock output divider: half period minus one, in system clocks
   localparam logic [DIV_W-1:0] REFCLK_HALF = 2'h1;
   localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;
   localparam logic [PHASE_W-1:0] PHASE_ONE = 4'h1;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   typedef enum logic [2:0]
   {
      ERW_IDLE = 3'b000,
      ERW_ADDR = 3'b001,
      ERW_CMD = 3'b010,
      ERW_MAND = 3'b011,
      ERW_RDY = 3'b100,
      ERW_HOLD = 3'b101
   } erw_state_e;
endpackage

/* File: hw/erw_sync_if.sv */
// Interface carrying the ready pin samples from the synchroniser.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface erw_sync_if;
   logic sync_lvl;
   logic async_lvl;
   modport src (output sync_lvl, output async_lvl);
   modport dst (input sync_lvl, input async_lvl);
endinterface

/* File: hw/erw_ready_sync.sv */
// Ready pin sampler: two-stage registered sample and extra stage.
// Assumes ready_pin may be asynchronous to clk_sys.
`timescale 1ns/1ps
module erw_ready_sync
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ready_pin,
   erw_sync_if.src smp
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
   } erw_sync_s;

   erw_sync_s q_r;
   erw_sync_s q_nxt;

   always_comb
   begin
      q_nxt = q_r;
      q_nxt.s1 = ready_pin;
      q_nxt.s2 = q_r.s1;
      // Extra stage costs one wait state in asynchronous mode
      q_nxt.s3 = q_r.s2;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign smp.sync_lvl = q_r.s2;
   assign smp.async_lvl = q_r.s3;
endmodule // erw_ready_sync

/* File: hw/erw_ready_ctrl.sv */
// External bus cycle sequencer with ready-controlled wait states.
// Assumes the request side holds req until ack and the external
// circuit drives ready_pin in accordance with the chosen mode.
//
// How it works
// - Ready input decides when a ready-controlled bus cycle ends.
// - Ready active level is selected by the ready_high input.
// - Asynchronous ready goes through one more stage, adding a wait.
// - First sample point follows each cycle's programmed phase lengths.
// - Inactive ready at a sample adds one wait state and resamples.
// - Active ready at a sample ends the bus cycle.
// - Synchronous and asynchronous modes use the same sample points.
// - Mandatory wait states complete before ready is evaluated.
// - Read data captured on the edge that raises the read strobe.
`timescale 1ns/1ps
module erw_ready_ctrl
#(
   parameter int unsigned PHASE_W = erw_pkg::PHASE_W,
   parameter int unsigned DATA_W = erw_pkg::DATA_W
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic req,
   input wire logic req_read,
   input wire logic [PHASE_W-1:0] addr_phase_len,
   input wire logic [PHASE_W-1:0] cmd_phase_len,
   input wire logic [PHASE_W-1:0] mandatory_wait_phase,
   input wire logic [PHASE_W-1:0] hold_phase_len,
   input wire logic ready_en,
   input wire logic ready_async,
   input wire logic ready_high,
   input wire logic ready_pin,
   input wire logic [DATA_W-1:0] data_pin,
   output logic bus_reference_clock_output,
   output logic rd_n,
   output logic wr_n,
   output logic ready_wait_phase,
   output logic ack,
   output logic [DATA_W-1:0] rdata,
   output logic busy
);
   typedef struct packed
   {
      erw_pkg::erw_state_e st;
      logic [PHASE_W-1:0] cnt;
      logic [erw_pkg::DIV_W-1:0] div;
      logic refclk;
      logic rd_n;
      logic wr_n;
      logic is_read;
      logic [PHASE_W-1:0] addr_len;
      logic en;
      logic asy;
      logic pol;
      logic [PHASE_W-1:0] cmd_len;
      logic [PHASE_W-1:0] mand_len;
      logic [PHASE_W-1:0] hold_len;
      logic wait_ph;
      logic ack;
      logic busy;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] din1;
      logic [DATA_W-1:0] din2;
   } erw_ctrl_s;

   erw_ctrl_s q_r;
   erw_ctrl_s q_nxt;
   erw_sync_if smp();

   erw_ready_sync u_sync
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ready_pin(ready_pin),
      .smp(smp)
   );

   // Level seen at the sample point, in the configured polarity
   function automatic logic rdy_seen(input logic asy, input logic pol,
                                     input logic s, input logic a);
      logic lvl;
      lvl = asy ? a : s;
      return pol ? lvl : !lvl;
   endfunction

   // Length 0 still takes one clock; address and mandatory phases of 0 are skipped
   function automatic logic last_clk(input logic [PHASE_W-1:0] c,
                                     input logic [PHASE_W-1:0] len);
      return (len == erw_pkg::PHASE_ZERO) || (c >= len - 1'b1);
   endfunction

   always_comb
   begin
      q_nxt = q_r;
      q_nxt.ack = 1'b0;
      q_nxt.din1 = data_pin;
      q_nxt.din2 = q_r.din1;
      // Free-running reference clock for the external circuit
      if (q_r.div == erw_pkg::REFCLK_HALF)
      begin
         q_nxt.div = '0;
         q_nxt.refclk = !q_r.refclk;
      end
      else
      begin
         q_nxt.div = q_r.div + 1'b1;
      end
      q_nxt.cnt = q_r.cnt + 1'b1;
      case (q_r.st)
         erw_pkg::ERW_IDLE:
         begin
            q_nxt.cnt = erw_pkg::PHASE_ZERO;
            if (req)
            begin
               // Phase lengths and mode latched per cycle
               q_nxt.is_read = req_read;
               q_nxt.addr_len = addr_phase_len;
               q_nxt.en = ready_en;
               q_nxt.asy = ready_async;
               q_nxt.pol = ready_high;
               q_nxt.cmd_len = cmd_phase_len;
               q_nxt.mand_len = mandatory_wait_phase;
               q_nxt.hold_len = hold_phase_len;
               q_nxt.busy = 1'b1;
               q_nxt.st = erw_pkg::ERW_ADDR;
               if (addr_phase_len == erw_pkg::PHASE_ZERO)
               begin
                  q_nxt.st = erw_pkg::ERW_CMD;
                  q_nxt.rd_n = !req_read;
                  q_nxt.wr_n = req_read;
               end
            end
         end
         erw_pkg::ERW_ADDR:
         begin
            if (last_clk(q_r.cnt, q_r.addr_len))
            begin
               q_nxt.cnt = erw_pkg::PHASE_ZERO;
               q_nxt.st = erw_pkg::ERW_CMD;
               q_nxt.rd_n = !q_r.is_read;
               q_nxt.wr_n = q_r.is_read;
            end
         end
         erw_pkg::ERW_CMD:
         begin
            if (last_clk(q_r.cnt, q_r.cmd_len))
            begin
               q_nxt.cnt = erw_pkg::PHASE_ZERO;
               // Sample point placed after programmed phases
               if (q_r.mand_len != erw_pkg::PHASE_ZERO)
                  q_nxt.st = erw_pkg::ERW_MAND;
               else if (q_r.en)
                  q_nxt.st = erw_pkg::ERW_RDY;
               else
                  q_nxt.st = erw_pkg::ERW_HOLD;
            end
         end
         erw_pkg::ERW_MAND:
         begin
            if (last_clk(q_r.cnt, q_r.mand_len))
            begin
               q_nxt.cnt = erw_pkg::PHASE_ZERO;
               // Ready not looked at until mandatory waits are done
               q_nxt.st = q_r.en ? erw_pkg::ERW_RDY
                                 : erw_pkg::ERW_HOLD;
            end
         end
         erw_pkg::ERW_RDY:
         begin
            q_nxt.cnt = erw_pkg::PHASE_ZERO;
            if (rdy_seen(q_r.asy, q_r.pol, smp.sync_lvl, smp.async_lvl))
            begin
               q_nxt.wait_ph = 1'b0;
               q_nxt.st = erw_pkg::ERW_HOLD;
            end
            else
            begin
               q_nxt.wait_ph = 1'b1;
            end
         end
         erw_pkg::ERW_HOLD:
         begin
            if (q_r.cnt == erw_pkg::PHASE_ZERO)
            begin
               // Strobe rises and read data latch on the same edge
               q_nxt.rd_n = 1'b1;
               q_nxt.wr_n = 1'b1;
               if (q_r.is_read)
                  q_nxt.rdata = q_r.din2;
            end
            if (last_clk(q_r.cnt, q_r.hold_len))
            begin
               q_nxt.cnt = erw_pkg::PHASE_ZERO;
               q_nxt.ack = 1'b1;
               q_nxt.busy = 1'b0;
               q_nxt.st = erw_pkg::ERW_IDLE;
            end
         end
         default:
         begin
            q_nxt.st = erw_pkg::ERW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         q_r <= '0;
         q_r.st <= erw_pkg::ERW_IDLE;
         q_r.rd_n <= 1'b1;
         q_r.wr_n <= 1'b1;
         q_r.rdata <= erw_pkg::DATA_RST;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign bus_reference_clock_output = q_r.refclk;
   assign rd_n = q_r.rd_n;
   assign wr_n = q_r.wr_n;
   assign ready_wait_phase = q_r.wait_ph;
   assign ack = q_r.ack;
   assign rdata = q_r.rdata;
   assign busy = q_r.busy;
endmodule // erw_ready_ctrl

/* File: test/erw_ready_ctrl_properties.sv */
// Port checker for the ready/wait-state sequencer.
// Assumes configuration inputs stay put while a cycle runs.
`timescale 1ns/1ps
module erw_rc_properties
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic req,
   input wire logic ready_en,
   input wire logic rd_n,
   input wire logic ready_wait_phase,
   input wire logic ack,
   input wire logic [erw_pkg::DATA_W-1:0] rdata,
   input wire logic busy
);
   // ****
   // Properties
   // ****
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   sequence s_end;
      ##[1:80] ack;
   endsequence
   a_cycle_ends: assert property ($rose(busy) |-> s_end)
      else $error("bus cycle did not end");
   a_req_taken: assert property (req && !busy && !ack |=> busy)
      else $error("request not taken");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_busy_ack: assert property ($fell(busy) |-> ack)
      else $error("busy fell without ack");
   a_wait_busy: assert property (ready_wait_phase |-> busy)
      else $error("wait state outside a cycle");
   a_wait_resample: assert property (ready_wait_phase |-> !ack[*2])
      else $error("cycle ended right after a wait");
   a_off_no_wait: assert property (!ready_en |-> !ready_wait_phase)
      else $error("wait state with ready control off");
   a_rdata_edge: assert property ($changed(rdata) |-> $rose(rd_n))
      else $error("read data moved off the strobe rise");
endmodule // erw_rc_properties

bind erw_ready_ctrl erw_rc_properties u_props
(
   .clk_sys(clk_sys),
   .resetn(resetn),
   .req(req),
   .ready_en(ready_en),
   .rd_n(rd_n),
   .ready_wait_phase(ready_wait_phase),
   .ack(ack),
   .rdata(rdata),
   .busy(busy)
);

/* File: test/erw_ext_model.sv */
// External circuit answering strobes with ready and read data.
// Assumes strobes are registered on the rising clock edge.
`timescale 1ns/1ps
module erw_ext_model
(
   input wire logic clk_sys,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic hi,
   input wire logic [3:0] dly,
   input wire logic [15:0] word,
   output logic ready_pin,
   output logic [15:0] data_pin
);
   int cnt = 0;
   int held = 0;
   logic rdy = 1'b0;
   // ****
   // Answer
   // ****
   // Delay 4'hF means never ready; hold covers one reference period
   always @(negedge clk_sys)
   begin
      cnt = (!rd_n || !wr_n) ? cnt + 1 : 0;
      held = held + 1;
      if (!rdy && cnt > 0 && cnt > dly && dly != 4'hF)
      begin
         rdy = 1'b1;
         held = 0;
      end
      else if (rdy && rd_n && wr_n && held >= 5)
         rdy = 1'b0;
      ready_pin = hi ? rdy : !rdy;
      data_pin = !rd_n ? word : ~word;
   end
endmodule // erw_ext_model

/* File: test/tb_top.sv */
// Self-checking bench for the ready/wait-state sequencer.
// Inputs change on the falling edge; the far side is modelled.
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic req = 1'b0;
   logic rd = 1'b1;
   logic [3:0] al = 4'h1;
   logic [3:0] hl = 4'h1;
   logic [3:0] cl = 4'h1;
   logic [3:0] ml = 4'h1;
   logic [3:0] dly = 4'h0;
   logic en = 1'b1;
   logic as = 1'b0;
   logic hi = 1'b1;
   logic [15:0] word = 16'h5AC3;
   logic rpin, rd_n, wr_n, rwp, ack, busy, refclk;
   logic [15:0] dpin, rdata;
   int bad_count = 0;
   int samples_checked = 0;
   always #20 clk_sys = ~clk_sys;
   erw_ready_ctrl DUT
   (
      .clk_sys(clk_sys), .resetn(resetn), .req(req), .req_read(rd),
      .addr_phase_len(al), .cmd_phase_len(cl),
      .mandatory_wait_phase(ml), .hold_phase_len(hl),
      .ready_en(en), .ready_async(as), .ready_high(hi),
      .ready_pin(rpin), .data_pin(dpin),
      .bus_reference_clock_output(refclk), .rd_n(rd_n), .wr_n(wr_n),
      .ready_wait_phase(rwp), .ack(ack), .rdata(rdata), .busy(busy)
   );
   erw_ext_model u_ext
   (
      .clk_sys(clk_sys), .rd_n(rd_n), .wr_n(wr_n), .hi(hi), .dly(dly),
      .word(word), .ready_pin(rpin), .data_pin(dpin)
   );
   // ****
   // Tasks
   // ****
   task automatic check(input string what, input int exp, input int got);
      samples_checked++;
      if (exp != got)
      begin
         bad_count++;
         $display("CHECK FAILED %s exp %0d got %0d", what, exp, got);
      end
   endtask
   // Lengths are compared pairwise, so fixed pipeline offsets cancel
   task automatic run(input logic [3:0] c, m, d, input logic a,
                      output int len, output int nw);
      cl = c;
      ml = m;
      dly = d;
      as = a;
      len = 0;
      nw = 0;
      repeat (8) @(negedge clk_sys);
      req = 1'b1;
      do
      begin
         @(negedge clk_sys);
         len++;
         nw += int'(rwp === 1'b1);
      end while (ack !== 1'b1 && len < 60);
      req = 1'b0;
      check("ack seen", 1, int'(len < 60));
   endtask
   task automatic t_wait;
      int a, b, wa, wb;
      check("reset", 1, int'({rd_n, wr_n, ack, busy} === 4'hC));
      run(4'h1, 4'h1, 4'h3, 1'b0, a, wa);
      run(4'h1, 4'h1, 4'h6, 1'b0, b, wb);
      check("wait len", 3, b - a);
      check("wait cnt", 3, wb - wa);
      run(4'h1, 4'h1, 4'h6, 1'b1, wa, wb);
      check("async len", a + 4, wa);
      $display("t_wait done");
   endtask
   task automatic t_phase;
      int a, b, wa, wb;
      run(4'h1, 4'h4, 4'h0, 1'b0, a, wa);
      run(4'h1, 4'h6, 4'h0, 1'b0, b, wb);
      check("mand len", 2, b - a);
      check("no wait", 0, wa + wb);
      run(4'h3, 4'h4, 4'h0, 1'b0, a, wa);
      run(4'h5, 4'h4, 4'h0, 1'b0, b, wb);
      check("cmd len", 2, b - a);
      run(4'h1, 4'h4, 4'h0, 1'b0, a, wa);
      al = 4'h0;
      run(4'h1, 4'h4, 4'h0, 1'b0, b, wb);
      check("addr len", 1, a - b);
      al = 4'h1;
      hl = 4'h3;
      run(4'h1, 4'h4, 4'h0, 1'b0, b, wb);
      check("hold len", 2, b - a);
      hl = 4'h1;
      $display("t_phase done");
   endtask
   task automatic t_data;
      int a, b, wa, wb;
      run(4'h1, 4'h1, 4'h6, 1'b0, a, wa);
      hi = 1'b0;
      word = 16'h3C96;
      run(4'h1, 4'h1, 4'h6, 1'b0, b, wb);
      check("polarity", a, b);
      check("rdata", 1, int'(rdata === 16'h3C96));
      rd = 1'b0;
      run(4'h1, 4'h1, 4'h2, 1'b0, b, wb);
      check("rdata kept", 1, int'(rdata === 16'h3C96));
      rd = 1'b1;
      hi = 1'b1;
      $display("t_data done");
   endtask
   task automatic t_off;
      int a, b, wa, wb;
      en = 1'b0;
      run(4'h1, 4'h1, 4'hF, 1'b0, a, wa);
      run(4'h1, 4'h1, 4'h0, 1'b0, b, wb);
      check("off len", a, b);
      check("off wait", 0, wa + wb);
      en = 1'b1;
      $display("t_off done");
   endtask
   // Reference clock is free running; both halves are measured
   task automatic t_refclk;
      int n_high, n_low;
      n_high = 0;
      n_low = 0;
      while (refclk !== 1'b1) @(negedge clk_sys);
      while (refclk === 1'b1 && n_high < 20)
      begin
         n_high++;
         @(negedge clk_sys);
      end
      while (refclk === 1'b0 && n_low < 20)
      begin
         n_low++;
         @(negedge clk_sys);
      end
      check("refclk high", int'(erw_pkg::REFCLK_HALF) + 1, n_high);
      check("refclk low", int'(erw_pkg::REFCLK_HALF) + 1, n_low);
      $display("t_refclk done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ****
   // Sequence
   // ****
   initial
   begin
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      t_wait;
      t_phase;
      t_data;
      t_off;
      t_refclk;
      tally_and_finish;
   end
   // About 15 cycles of at most 68 clocks each fit well inside this
   initial
   begin
      #200000;
      bad_count++;
      tally_and_finish;
   end
endmodule // tb_top
